// ---- hdl/fsrc_defs.svh ----
/*
 Offsets, field positions, reset values and command codes of the
 flash status and read configuration block.
 Assumes it is included by the top module, the host model and the bench.
*/
// Notes on behaviour
// - Read-status command is taken at any address; status returned after.
// - After program, erase or lock sequences, reads return status.
// - Status read drives the status byte low and zero on bits 15:8.
// - Async reads latch fresh status on last OE or CE fall.
// - Async page: first word valid; burst repeats the word to length.
// - Bit 7 reads 0 busy, 1 ready; status resets to 0x80.
// - Bit 6 shows erase suspend, bit 2 program suspend, in effect.
// - Bits 5:4 encode success, program, erase or sequence error; abort.
// - Bit 3 sets when program/erase supply is at or below lockout.
// - Bit 1 sets on locked-block abort; bit 0 shows buffer loading.
// - Clear ignores supply; bits 5,4,3,1 sticky until cleared.
// - Device reset clears status like the clear command.
// - Config written only by configure command; read at ident 0x05.
// - Config bit 15 picks burst (0) or async page (1); resets async.
// - Config bits 14:11 hold latency code, default 15.
// - Config bit 10 sets wait polarity: 0 low, 1 high.
// - Config bit 8 set deasserts wait one data cycle early.
// - Config bit 6 picks clock edge: 0 falling, 1 rising.
// - Bit 3 wrap off; bits 2:0 pick 4, 8, 16 or continuous; the code stores bit 3 but never reads it.
`ifndef FSRC_DEFS_SVH
`define FSRC_DEFS_SVH

`define FSRC_RCR_OFFSET   16'h0005
`define FSRC_RCR_RESET    16'hF94F
`define FSRC_RCR_WMASK    16'hFD4F
`define FSRC_STATUS_RESET 8'h80

`define FSRC_RCR_MODE  15
`define FSRC_RCR_LC_HI 14
`define FSRC_RCR_LC_LO 11
`define FSRC_RCR_WPOL  10
`define FSRC_RCR_WDLY  8
`define FSRC_RCR_EDGE  6
`define FSRC_RCR_WRAP  3
`define FSRC_RCR_BL_HI 2
`define FSRC_RCR_BL_LO 0

`define FSRC_BL_4      3'h1
`define FSRC_BL_8      3'h2
`define FSRC_BL_16     3'h3
`define FSRC_WORDS_4   5'h04
`define FSRC_WORDS_8   5'h08
`define FSRC_WORDS_16  5'h10

`define FSRC_CMD_ARRAY   8'hFF
`define FSRC_CMD_STATUS  8'h70
`define FSRC_CMD_CLEAR   8'h50
`define FSRC_CMD_IDENT   8'h90
`define FSRC_CMD_SETUP   8'h60
`define FSRC_CMD_CONFIG  8'h03
`define FSRC_CMD_LOCK    8'h01
`define FSRC_CMD_CONFIRM 8'hD0
`define FSRC_CMD_LDOWN   8'h2F
`define FSRC_CMD_PROG    8'h40
`define FSRC_CMD_PROG2   8'h10
`define FSRC_CMD_ERASE   8'h20
`define FSRC_CMD_SUSPEND 8'hB0

`endif

// ---- hdl/fsrc_pkg.sv ----
/*
 Types shared by the flash status and read configuration block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package fsrc_pkg;
  // What a read returns
  typedef enum logic [1:0] {
    RM_ARRAY,
    RM_STATUS,
    RM_IDENT
  } fsrc_read_mode_type;

  // Progress of a two-write command sequence
  typedef enum logic [1:0] {
    CS_IDLE,
    CS_SETUP,
    CS_PROG,
    CS_ERASE
  } fsrc_cmd_state_type;
endpackage

// ---- hdl/fsrc_sync.sv ----
/*
 Two-stage synchroniser for a group of pin levels.
 Assumes the bits of a group are stable around the sampling point.
*/
`timescale 1ns/1ns
`default_nettype none
module fsrc_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_ff;

  // First stage feeds only the second one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= RST_VAL;
      q       <= RST_VAL;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/fsrc_top.sv ----
/*
 Status register and read configuration register of a parallel NOR
 flash, with command decode, read latching and burst wait logic.
 Assumes pins arrive asynchronously and the program/erase engine
 runs on CORE_CLK and reports through ENG_* inputs.
*/
`timescale 1ns/1ns
`default_nettype none
`include "fsrc_defs.svh"
module fsrc_top (
  input  wire logic        CORE_CLK,
  input  wire logic        RESET_N,
  input  wire logic        CE_N,
  input  wire logic        OE_N,
  input  wire logic        WE_N,
  input  wire logic        ADDRESS_VALID_N,
  input  wire logic        LINK_CLK,
  input  wire logic [15:0] ADDR,
  input  wire logic [15:0] DQ_IN,
  output logic      [15:0] DQ_OUT,
  output logic             DQ_OE_N,
  output logic             WAIT_OUT,
  output logic             WAIT_OE_N,
  input  wire logic [15:0] ARRAY_DATA,
  input  wire logic        ENG_BUSY,
  input  wire logic        ENG_ERASE_SUSP,
  input  wire logic        ENG_PROG_SUSP,
  input  wire logic        ENG_BUF_LOAD,
  input  wire logic        ENG_PROG_ERR,
  input  wire logic        ENG_ERASE_ERR,
  input  wire logic        ENG_SUPPLY_LOW,
  input  wire logic        ENG_LOCK_ABORT,
  output logic             CMD_VALID,
  output logic      [7:0]  CMD_CODE,
  output logic      [15:0] CMD_ADDR,
  output logic      [15:0] CMD_DATA,
  output logic             ABORT_OP
);
  logic [4:0]  pin_s;
  logic [31:0] bus_s;
  logic        clk_d_ff, we_d_ff, rd_d_ff;
  logic [15:0] rcr_ff, hold_ff;
  logic        ready_ff, esusp_ff, psusp_ff, bufl_ff;
  logic [1:0]  err_ff;
  logic        supply_ff, lock_ff;
  logic        burst_ff;
  logic [3:0]  lat_ff;
  logic [4:0]  word_ff;
  fsrc_pkg::fsrc_read_mode_type mode_ff, nxt_mode;
  fsrc_pkg::fsrc_cmd_state_type cs_ff, nxt_cs;

  // Pins cross into CORE_CLK before anything looks at them
  // Link clock resets to its idle low level, so no false edge follows reset
  fsrc_sync #(.WIDTH(5), .RST_VAL(5'h1E)) u_pin_sync (
    .clk   (CORE_CLK),
    .rst_n (RESET_N),
    .d     ({CE_N, OE_N, WE_N, ADDRESS_VALID_N, LINK_CLK}),
    .q     (pin_s)
  );

  // Address and data are stable at write and read edges
  fsrc_sync #(.WIDTH(32), .RST_VAL(32'h0000_0000)) u_bus_sync (
    .clk   (CORE_CLK),
    .rst_n (RESET_N),
    .d     ({ADDR, DQ_IN}),
    .q     (bus_s)
  );

  // Pin decode
  wire        ce_n_s  = pin_s[4];
  wire        oe_n_s  = pin_s[3];
  wire        we_n_s  = pin_s[2];
  wire        adv_n_s = pin_s[1];
  wire        lclk_s  = pin_s[0];
  wire [15:0] addr_s  = bus_s[31:16];
  wire [15:0] wdata_s = bus_s[15:0];
  wire [7:0]  cbyte   = wdata_s[7:0];

  // Configuration fields
  wire       sync_mode = ~rcr_ff[`FSRC_RCR_MODE];
  wire [3:0] lc        = rcr_ff[`FSRC_RCR_LC_HI:`FSRC_RCR_LC_LO];
  wire       wpol      = rcr_ff[`FSRC_RCR_WPOL];
  wire       wdly      = rcr_ff[`FSRC_RCR_WDLY];
  wire       rise_edge = rcr_ff[`FSRC_RCR_EDGE];
  wire [2:0] bl        = rcr_ff[`FSRC_RCR_BL_HI:`FSRC_RCR_BL_LO];

  // Link clock edges are found by sampling, not by clocking on it
  wire lrise   = lclk_s & ~clk_d_ff;
  wire lfall   = ~lclk_s & clk_d_ff;
  wire clk_act = rise_edge ? lrise : lfall;

  // Bus phases
  wire we_rise  = we_n_s & ~we_d_ff & ~ce_n_s;
  wire rd_act   = ~ce_n_s & ~oe_n_s & we_n_s;
  wire bus_on   = ~ce_n_s & ~oe_n_s;
  // last of OE or CE falling
  wire rd_start = rd_act & ~rd_d_ff;
  wire b_start  = sync_mode & ~ce_n_s & ~adv_n_s & clk_act;
  wire refresh  = sync_mode ? b_start : rd_start;

  // ready bit and suspend bits are live
  wire [7:0] status = {ready_ff, esusp_ff, err_ff, supply_ff,
                       psusp_ff, lock_ff, bufl_ff};

  // Command decode strobes
  wire clr_cmd  = we_rise & (cs_ff == fsrc_pkg::CS_IDLE) &
                  (cbyte == `FSRC_CMD_CLEAR);
  wire cfg_wr   = we_rise & (cs_ff == fsrc_pkg::CS_SETUP) &
                  (cbyte == `FSRC_CMD_CONFIG);
  wire lock_ok  = (cbyte == `FSRC_CMD_LOCK) |
                  (cbyte == `FSRC_CMD_CONFIRM) |
                  (cbyte == `FSRC_CMD_LDOWN);
  wire seq_err  = we_rise &
                  (((cs_ff == fsrc_pkg::CS_SETUP) & ~lock_ok &
                    (cbyte != `FSRC_CMD_CONFIG)) |
                   ((cs_ff == fsrc_pkg::CS_ERASE) &
                    (cbyte != `FSRC_CMD_CONFIRM)));
  wire any_err  = ENG_PROG_ERR | ENG_ERASE_ERR | seq_err |
                  ENG_SUPPLY_LOW | ENG_LOCK_ABORT;
  wire eng_cmd  = we_rise & ~cfg_wr & ~seq_err &
                  (cs_ff != fsrc_pkg::CS_IDLE);
  wire pass_cmd = we_rise & (cs_ff == fsrc_pkg::CS_IDLE) &
                  ((cbyte == `FSRC_CMD_SUSPEND) |
                   (cbyte == `FSRC_CMD_CONFIRM));

  // Command sequencer and read mode selection
  always_comb begin
    nxt_cs   = cs_ff;
    nxt_mode = mode_ff;
    if (we_rise) begin
      case (cs_ff)
        fsrc_pkg::CS_IDLE: begin
          case (cbyte)
            `FSRC_CMD_STATUS: nxt_mode = fsrc_pkg::RM_STATUS;
            `FSRC_CMD_ARRAY:  nxt_mode = fsrc_pkg::RM_ARRAY;
            `FSRC_CMD_IDENT:  nxt_mode = fsrc_pkg::RM_IDENT;
            `FSRC_CMD_SETUP:  nxt_cs   = fsrc_pkg::CS_SETUP;
            `FSRC_CMD_PROG:   nxt_cs   = fsrc_pkg::CS_PROG;
            `FSRC_CMD_PROG2:  nxt_cs   = fsrc_pkg::CS_PROG;
            `FSRC_CMD_ERASE:  nxt_cs   = fsrc_pkg::CS_ERASE;
            `FSRC_CMD_SUSPEND: nxt_mode = fsrc_pkg::RM_STATUS;
            default:          nxt_mode = mode_ff;
          endcase
        end
        fsrc_pkg::CS_SETUP: begin
          nxt_cs = fsrc_pkg::CS_IDLE;
          if (!cfg_wr) begin
            nxt_mode = fsrc_pkg::RM_STATUS;
          end
        end
        default: begin
          nxt_cs   = fsrc_pkg::CS_IDLE;
          nxt_mode = fsrc_pkg::RM_STATUS;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cs_ff   <= fsrc_pkg::CS_IDLE;
      mode_ff <= fsrc_pkg::RM_ARRAY;
    end else begin
      cs_ff   <= nxt_cs;
      mode_ff <= nxt_mode;
    end
  end

  // Edge history of sampled pins
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      clk_d_ff <= 1'b0;
      we_d_ff  <= 1'b1;
      rd_d_ff  <= 1'b0;
    end else begin
      clk_d_ff <= lclk_s;
      we_d_ff  <= we_n_s;
      rd_d_ff  <= rd_act;
    end
  end

  // sticky bits; an event in the clearing cycle wins
  wire [1:0] nxt_err = {ENG_ERASE_ERR | seq_err, ENG_PROG_ERR | seq_err}
                       | (err_ff & {2{~clr_cmd}});
  wire nxt_supply    = ENG_SUPPLY_LOW | (supply_ff & ~clr_cmd);
  wire nxt_lock      = ENG_LOCK_ABORT | (lock_ff & ~clr_cmd);

  // reset clears the status like the clear command
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      {ready_ff, esusp_ff, err_ff, supply_ff,
       psusp_ff, lock_ff, bufl_ff} <= `FSRC_STATUS_RESET;
    end else begin
      ready_ff  <= ~ENG_BUSY;
      // suspends set and cleared by hardware
      esusp_ff  <= ENG_ERASE_SUSP;
      psusp_ff  <= ENG_PROG_SUSP;
      err_ff    <= nxt_err;
      supply_ff <= nxt_supply;
      lock_ff   <= nxt_lock;
      bufl_ff   <= ENG_BUF_LOAD;
    end
  end

  // configure command is the only writer
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rcr_ff <= `FSRC_RCR_RESET;
    end else if (cfg_wr) begin
      rcr_ff <= addr_s & `FSRC_RCR_WMASK;
    end
  end

  // Word that a read returns now
  // status on the low byte, upper byte zero
  wire [15:0] id_word = (addr_s == `FSRC_RCR_OFFSET) ?
                        rcr_ff : 16'h0000;
  wire [15:0] rd_word = (mode_ff == fsrc_pkg::RM_STATUS) ?
                        {8'h00, status} :
                        (mode_ff == fsrc_pkg::RM_IDENT) ?
                        id_word : ARRAY_DATA;
  wire nonarray = mode_ff != fsrc_pkg::RM_ARRAY;

  // status latched once per access, not tracked
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      hold_ff <= 16'h0000;
    end else if (refresh) begin
      hold_ff <= rd_word;
    end
  end

  // Burst length in words; zero means continuous
  wire [4:0] len = (bl == `FSRC_BL_4)  ? `FSRC_WORDS_4 :
                   (bl == `FSRC_BL_8)  ? `FSRC_WORDS_8 :
                   (bl == `FSRC_BL_16) ? `FSRC_WORDS_16 : 5'h00;
  wire valid     = burst_ff & (lat_ff >= lc);
  wire done      = (len != 5'h00) & (word_ff >= len);
  // early deassert moves the threshold one edge
  wire [3:0] thr = lc - {3'h0, wdly};
  wire wait_on   = sync_mode & burst_ff & (lat_ff < thr);

  // latency counts link edges from the address strobe
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      burst_ff <= 1'b0;
      lat_ff   <= 4'h0;
      word_ff  <= 5'h00;
    end else if (b_start) begin
      burst_ff <= 1'b1;
      lat_ff   <= 4'h1;
      word_ff  <= 5'h00;
    end else if (ce_n_s | ~sync_mode) begin
      burst_ff <= 1'b0;
    end else if (clk_act & burst_ff) begin
      if (lat_ff < lc) begin
        lat_ff <= lat_ff + 4'h1;
      end
      // count words toward the burst length
      if (valid & ~done) begin
        word_ff <= word_ff + 5'h01;
      end
    end
  end

  // nonarray word repeats; async page holds first word
  wire [15:0] nxt_dq   = nonarray ? hold_ff : ARRAY_DATA;
  wire        dq_drive = rd_act & (~sync_mode | (valid & ~done));
  // polarity; async reads keep wait deasserted
  wire        nxt_wait = wait_on ? wpol : ~wpol;

  // Pin drivers; enables are low while driving
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      DQ_OUT    <= 16'h0000;
      DQ_OE_N   <= 1'b1;
      WAIT_OUT  <= 1'b1;
      WAIT_OE_N <= 1'b1;
    end else begin
      DQ_OUT    <= nxt_dq;
      DQ_OE_N   <= ~dq_drive;
      WAIT_OUT  <= nxt_wait;
      WAIT_OE_N <= ~bus_on;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CMD_VALID <= 1'b0;
      CMD_CODE  <= 8'h00;
      CMD_ADDR  <= 16'h0000;
      CMD_DATA  <= 16'h0000;
      ABORT_OP  <= 1'b0;
    end else begin
      CMD_VALID <= eng_cmd | pass_cmd;
      ABORT_OP  <= any_err;
      if (eng_cmd | pass_cmd) begin
        CMD_CODE <= cbyte;
        CMD_ADDR <= addr_s;
        CMD_DATA <= wdata_s;
      end
    end
  end

  // Checks
  property p_status_word;
    @(posedge CORE_CLK) disable iff (!RESET_N)
    (refresh && mode_ff == fsrc_pkg::RM_STATUS)
      |=> hold_ff == {8'h00, $past(status)};
  endproperty
  a_status_word: assert property (p_status_word)
    else $error("status word not latched with zero high byte");

  property p_busy_bit;
    @(posedge CORE_CLK) disable iff (!RESET_N)
    ENG_BUSY [*2] |-> status[7] == 1'b0;
  endproperty
  a_busy_bit: assert property (p_busy_bit)
    else $error("ready bit high while engine busy");

  property p_sticky;
    @(posedge CORE_CLK) disable iff (!RESET_N)
    !clr_cmd |=> (~{err_ff, supply_ff, lock_ff} &
                  $past({err_ff, supply_ff, lock_ff})) == 4'h0;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("sticky status bit lost without clear");

  property p_clear;
    @(posedge CORE_CLK) disable iff (!RESET_N)
    (clr_cmd && !any_err) |=> (status[5:3] == 3'h0 && status[1] == 1'b0);
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear command left error bits set");

  property p_set_wins;
    @(posedge CORE_CLK) disable iff (!RESET_N)
    (ENG_PROG_ERR && clr_cmd) |=> err_ff[0];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("error event lost against clear");

  property p_abort;
    @(posedge CORE_CLK) disable iff (!RESET_N)
    ENG_LOCK_ABORT |=> ABORT_OP && lock_ff;
  endproperty
  a_abort: assert property (p_abort)
    else $error("lock abort not flagged and aborted");

  property p_cfg_write;
    @(posedge CORE_CLK) disable iff (!RESET_N)
    cfg_wr |=> rcr_ff == ($past(addr_s) & `FSRC_RCR_WMASK);
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("configuration write not stored");

  property p_reserved;
    @(posedge CORE_CLK) disable iff (!RESET_N)
    $changed(rcr_ff) |-> (rcr_ff[9] | rcr_ff[7] | rcr_ff[5] | rcr_ff[4])
      == 1'b0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved configuration bit set");

  property p_status_mode;
    @(posedge CORE_CLK) disable iff (!RESET_N)
    (we_rise && cs_ff == fsrc_pkg::CS_PROG)
      |=> mode_ff == fsrc_pkg::RM_STATUS;
  endproperty
  a_status_mode: assert property (p_status_mode)
    else $error("no status mode after program");

  property p_async_wait;
    @(posedge CORE_CLK) disable iff (!RESET_N)
    (!sync_mode && bus_on) |=> WAIT_OUT == !$past(wpol);
  endproperty
  a_async_wait: assert property (p_async_wait)
    else $error("wait asserted during async read");

  c_burst: cover property (@(posedge CORE_CLK) b_start ##[1:200] valid);
  c_cfg: cover property (@(posedge CORE_CLK) cfg_wr);
  c_seq: cover property (@(posedge CORE_CLK) seq_err ##1 ABORT_OP);
endmodule
`default_nettype wire

// ---- verif/fsrc_host.sv ----
/*
 Host controller model that drives the flash pins for the bench.
 Assumes its tasks are called one at a time from a single process.
*/
`timescale 1ns/1ns
`default_nettype none
`include "fsrc_defs.svh"
module fsrc_host #(
  parameter int CLEAR_WAIT = 3750
) (
  input  wire logic        clk,
  output logic             ce_n,
  output logic             oe_n,
  output logic             we_n,
  output logic             address_valid_n,
  output logic             link_clk,
  output logic      [15:0] addr,
  output logic      [15:0] dq_in
);
  // Idle pins; the burst clock stands still between frames
  initial begin
    ce_n = 1'b1;
    oe_n = 1'b1;
    we_n = 1'b1;
    address_valid_n = 1'b1;
    link_clk = 1'b0;
    addr = 16'h0000;
    dq_in = 16'hFFFF;
  end

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic write_cmd(input logic [7:0] code, input logic [15:0] a);
    @(posedge clk);
    addr <= a;
    dq_in <= {8'h00, code};
    ce_n <= 1'b0;
    we_n <= 1'b0;
    idle(6);
    we_n <= 1'b1;
    idle(6);
    ce_n <= 1'b1;
    dq_in <= ~{8'h00, code}; // Released lines never keep the old value
    idle(4);
  endtask

  task automatic clear_status();
    idle(CLEAR_WAIT);
    write_cmd(`FSRC_CMD_CLEAR, 16'h0000);
  endtask

  task automatic open_rd(input logic [15:0] a, input logic adv_n);
    @(posedge clk);
    addr <= a;
    ce_n <= 1'b0;
    oe_n <= 1'b0;
    address_valid_n <= adv_n;
  endtask

  task automatic set_addr(input logic [15:0] a);
    @(posedge clk);
    addr <= a;
  endtask

  task automatic close_rd();
    @(posedge clk);
    ce_n <= 1'b1;
    oe_n <= 1'b1;
    address_valid_n <= 1'b1;
    idle(4);
  endtask

  task automatic link_cycle();
    idle(20);
    link_clk <= 1'b1;
    idle(20);
    link_clk <= 1'b0;
    address_valid_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- verif/fsrc_tb_top.sv ----
/*
 Self-checking bench for the flash status and read configuration block.
 Assumes the design files and the host model are compiled before it.
*/
`timescale 1ns/1ns
`default_nettype none
`include "fsrc_defs.svh"
module fsrc_tb_top;
  typedef struct packed {
    logic [7:0] eng;
    logic       pulse;
    logic [7:0] exp;
  } fsrc_row_type;

  logic         core_clk;
  logic         reset_n;
  logic         ce_n;
  logic         oe_n;
  logic         we_n;
  logic         adv_n;
  logic         link_clk;
  logic [15:0]  addr;
  logic [15:0]  dq_in;
  logic [15:0]  dq_out;
  logic         dq_oe_n;
  logic         wait_out;
  logic         wait_oe_n;
  logic [15:0]  array_data;
  logic [7:0]   eng;
  logic         cmd_valid;
  logic [7:0]   cmd_code;
  logic [15:0]  cmd_addr;
  logic [15:0]  cmd_data;
  logic         abort_op;
  logic [7:0]   last_code;
  logic [15:0]  got;
  int           n_errors;
  int           samples_checked;
  int           n_abort;
  int           ab0;
  fsrc_row_type rows [8];

  // 250 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  fsrc_host host (
    .clk             (core_clk),
    .ce_n            (ce_n),
    .oe_n            (oe_n),
    .we_n            (we_n),
    .address_valid_n (adv_n),
    .link_clk        (link_clk),
    .addr            (addr),
    .dq_in           (dq_in)
  );

  fsrc_top DUT (
    .CORE_CLK        (core_clk),
    .RESET_N         (reset_n),
    .CE_N            (ce_n),
    .OE_N            (oe_n),
    .WE_N            (we_n),
    .ADDRESS_VALID_N (adv_n),
    .LINK_CLK        (link_clk),
    .ADDR            (addr),
    .DQ_IN           (dq_in),
    .DQ_OUT          (dq_out),
    .DQ_OE_N         (dq_oe_n),
    .WAIT_OUT        (wait_out),
    .WAIT_OE_N       (wait_oe_n),
    .ARRAY_DATA      (array_data),
    .ENG_BUSY        (eng[7]),
    .ENG_ERASE_SUSP  (eng[6]),
    .ENG_PROG_SUSP   (eng[5]),
    .ENG_BUF_LOAD    (eng[4]),
    .ENG_PROG_ERR    (eng[3]),
    .ENG_ERASE_ERR   (eng[2]),
    .ENG_SUPPLY_LOW  (eng[1]),
    .ENG_LOCK_ABORT  (eng[0]),
    .CMD_VALID       (cmd_valid),
    .CMD_CODE        (cmd_code),
    .CMD_ADDR        (cmd_addr),
    .CMD_DATA        (cmd_data),
    .ABORT_OP        (abort_op)
  );

  // Abort pulses counted; forwarded command code remembered
  always @(posedge core_clk) begin
    if (abort_op === 1'b1)
      n_abort <= n_abort + 1;
    if (cmd_valid === 1'b1)
      last_code <= cmd_code;
  end

  task automatic chk_word(input string what, input logic [15:0] exp,
                          input logic [15:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp,
                         input logic seen);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %b seen %b", what, exp, seen);
    end
  endtask

  // Word is on the pins two edges after sync, so seven is safe
  task automatic rd_word(input logic [15:0] a, output logic [15:0] w);
    host.open_rd(a, 1'b1);
    host.idle(7);
    @(negedge core_clk) w = dq_out;
    host.close_rd();
  endtask

  task automatic rd_status(output logic [15:0] w);
    host.write_cmd(`FSRC_CMD_STATUS, 16'h00A0);
    rd_word(16'h0000, w);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Whole run needs about 32000 cycles
  initial begin
    repeat (90000) @(posedge core_clk);
    n_errors++;
    tally_and_finish();
  end

  initial begin
    reset_n = 1'b0;
    eng = 8'h00;
    last_code = 8'h00;
    array_data = 16'hA5C3;
    // Engine inputs beside the status byte they should give
    rows[0] = '{8'h80, 1'b0, 8'h00};
    rows[1] = '{8'h40, 1'b0, 8'hC0};
    rows[2] = '{8'h20, 1'b0, 8'h84};
    rows[3] = '{8'h10, 1'b0, 8'h81};
    rows[4] = '{8'h08, 1'b1, 8'h90};
    rows[5] = '{8'h04, 1'b1, 8'hA0};
    rows[6] = '{8'h02, 1'b1, 8'h88};
    rows[7] = '{8'h01, 1'b1, 8'h82};
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    host.idle(2);
    host.write_cmd(`FSRC_CMD_IDENT, 16'h0000);
    rd_word(`FSRC_RCR_OFFSET, got);
    chk_word("config reset", 16'hF94F, got);
    rd_word(16'h0004, got);
    chk_word("ident other", 16'h0000, got);
    rd_status(got);
    chk_word("status reset", 16'h0080, got);
    host.write_cmd(`FSRC_CMD_ARRAY, 16'h0000);
    rd_word(16'h0010, got);
    chk_word("array", 16'hA5C3, got);
    array_data <= 16'h3C5A;
    rd_word(16'h0011, got);
    chk_word("array second", 16'h3C5A, got);
    $display("test defaults done");
    // Levels are held through the read, pulses last one cycle
    for (int i = 0; i < 8; i++) begin
      ab0 = n_abort;
      eng <= rows[i].eng;
      host.idle(1);
      if (rows[i].pulse)
        eng <= 8'h00;
      rd_status(got);
      chk_word("status", {8'h00, rows[i].exp}, got);
      chk_bit("abort", rows[i].pulse, n_abort != ab0);
      eng <= 8'h00;
      host.clear_status();
      rd_status(got);
      chk_word("cleared", 16'h0080, got);
    end
    $display("test status rows done");
    // Held read must not track the busy change, page words repeat
    host.write_cmd(`FSRC_CMD_STATUS, 16'h0000);
    host.open_rd(16'h0000, 1'b1);
    host.idle(7);
    eng <= 8'h80;
    host.set_addr(16'h0003);
    host.idle(8);
    @(negedge core_clk) got = dq_out;
    chk_word("held status", 16'h0080, got);
    chk_bit("wait enable", 1'b0, wait_oe_n);
    host.close_rd();
    rd_word(16'h0000, got);
    chk_word("fresh status", 16'h0000, got);
    eng <= 8'h00;
    $display("test latch done");
    // Error pulse lands in the very cycle the clear is taken: set wins
    fork
      host.write_cmd(`FSRC_CMD_CLEAR, 16'h0000);
      begin
        repeat (9) @(posedge core_clk);
        eng <= 8'h08;
        @(posedge core_clk) eng <= 8'h00;
      end
    join
    rd_status(got);
    chk_word("set beats clear", 16'h0090, got);
    $display("test set against clear done");
    host.write_cmd(`FSRC_CMD_SETUP, 16'h0000);
    host.write_cmd(`FSRC_CMD_CONFIG, 16'hFFFF);
    host.write_cmd(`FSRC_CMD_IDENT, 16'h0000);
    rd_word(`FSRC_RCR_OFFSET, got);
    chk_word("config reserved", 16'hFD4F, got);
    ab0 = n_abort;
    host.write_cmd(`FSRC_CMD_SETUP, 16'h0000);
    host.write_cmd(`FSRC_CMD_ARRAY, 16'h0000);
    rd_word(16'h0000, got);
    chk_word("sequence error", 16'h00B0, got);
    chk_bit("sequence abort", 1'b1, n_abort != ab0);
    // Reset in mid-run drops the sticky error and the config
    reset_n <= 1'b0;
    host.idle(3);
    reset_n <= 1'b1;
    host.idle(2);
    rd_status(got);
    chk_word("status after reset", 16'h0080, got);
    host.write_cmd(`FSRC_CMD_IDENT, 16'h0000);
    rd_word(`FSRC_RCR_OFFSET, got);
    chk_word("config after reset", 16'hF94F, got);
    host.write_cmd(`FSRC_CMD_ARRAY, 16'h0000);
    host.write_cmd(`FSRC_CMD_ERASE, 16'h0040);
    host.write_cmd(`FSRC_CMD_CONFIRM, 16'h0040);
    chk_word("forwarded", 16'h00D0, {8'h00, last_code});
    rd_word(16'h0000, got);
    chk_word("status after erase", 16'h0080, got);
    host.write_cmd(`FSRC_CMD_PROG, 16'h0041);
    host.write_cmd(8'h3C, 16'h0041);
    chk_word("command address", 16'h0041, cmd_addr);
    chk_word("command data", 16'h003C, cmd_data);
    rd_word(16'h0000, got);
    chk_word("status after program", 16'h0080, got);
    $display("test errors and reset done");
    // Burst: latency 3, wait active low, late deassert, 4 words
    host.write_cmd(`FSRC_CMD_SETUP, 16'h0000);
    host.write_cmd(`FSRC_CMD_CONFIG, 16'h1849);
    host.write_cmd(`FSRC_CMD_STATUS, 16'h0000);
    host.open_rd(16'h0000, 1'b0);
    host.link_cycle();
    @(negedge core_clk) chk_bit("wait early", 1'b0, wait_out);
    host.link_cycle();
    host.link_cycle();
    @(negedge core_clk) chk_bit("wait done", 1'b1, wait_out);
    chk_bit("burst drive", 1'b0, dq_oe_n);
    chk_word("burst word", 16'h0080, dq_out);
    host.link_cycle();
    host.link_cycle();
    @(negedge core_clk) chk_word("burst repeat", 16'h0080, dq_out);
    repeat (4) host.link_cycle();
    @(negedge core_clk) chk_bit("burst end", 1'b1, dq_oe_n);
    host.close_rd();
    $display("test burst done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
